// ==== design/wcm_pkg.sv ====
// Functional notes
// - 4096 entry pairs; each entry holds 32-bit word and 9-bit tag
// - Pair index is address bits 9..20 from processor or adapter
// - Bit 21 picks even/odd, bits 0..8 are the tag, low bits ignored
// - Cache writes of 1, 4 or 8 bytes, pulses decoded from processor ops
// - Byte write replaces one byte picked by bits 21..23
// - Word write by tag and bit 21; doubleword write by tag only
// - With no write and cache-read bit set, fill writes whole doubleword
// - Four data parity bits per word, one tag parity bit, written together
// - Adapter write invalidates the indexed entry on tag match
// - Adapter doubleword read goes straight to adapter, cache untouched
// - Adapter addresses only invalidate, never allocate
// - Hit drives cache word to memory data register; memory word blocked
// - Main memory gets the address of the requester owning the operation
// - Tag mismatch raises miss, halts processor, starts doubleword read
// - Every miss recorded in condition register for diagnostics
// - Tag or data parity error forces a miss
// - Separate even/odd valid bits; invalid read misses; refill revalidates
// - On miss memory word forwarded with cache drive off; messages uncached
// - Halfword writes accepted only from adapter, not processor
// - Processor op decoded only with no adapter request; adapter by op code
// - Halt on miss, and on processor write while busy, refresh or adapter
// - Refresh every 15 us with row bits 6..13; refresh wins priority
// - Disable bit makes every processor read a memory doubleword read
// - All entries invalid at reset and when cache is re-enabled
package wcm_pkg;
    // Address bits, numbered here with bit 0 as least significant
    localparam int A_TAG_HI = 23;
    localparam int A_TAG_LO = 15;
    localparam int A_IDX_LO = 3;
    localparam int A_ODD    = 2;
    localparam int A_ROW_LO = 10;
    localparam int TAG_W    = 9;
    localparam int IDX_W_D  = 12;
    localparam int ROW_W    = 8;
    localparam int RT_W     = 16;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int REF_US   = 15;
    localparam int CLK_MHZ  = 25;
    localparam int REF_CYC  = REF_US * CLK_MHZ;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STAT = 4'h4;
    localparam int CTRL_DIS  = 0;
    localparam int STAT_MISS = 0;
    localparam int STAT_PERR = 1;
    localparam int STAT_BUSY = 2;
    localparam int STAT_ROW  = 8;
    // Adapter op codes
    localparam logic [2:0] ADP_RD_DW = 3'h0;
    localparam logic [2:0] ADP_WR_HW = 3'h1;
    localparam logic [2:0] ADP_WR_W  = 3'h2;
    localparam logic [2:0] ADP_WR_DW = 3'h3;
    localparam logic [2:0] ADP_IPC   = 3'h4;
    localparam logic [2:0] ADP_WR_B  = 3'h5;

    typedef enum logic [2:0] {
        CPU_NONE, CPU_READ, CPU_WR_BYTE, CPU_WR_HALF, CPU_WR_WORD, CPU_WR_DWORD
    } wcm_cpu_op_t;
    typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD, SZ_DWORD} wcm_size_t;
    typedef enum logic [1:0] {MEM_NOP, MEM_READ, MEM_WRITE, MEM_REFRESH} wcm_mem_op_t;

    typedef struct packed {
        logic [31:0]      data;
        logic [3:0]       dpar;
        logic [TAG_W-1:0] tag;
        logic             tpar;
        logic             v;
    } wcm_ent_t;
    typedef struct packed {
        wcm_cpu_op_t op;
        logic        cache_read_request_bit;
        logic [23:0] cpu_memory_address;
        logic [63:0] wdata;
    } wcm_cpu_req_t;
    typedef struct packed {
        logic [31:0] memory_data_register;
        logic        drive;
        logic        load;
        logic        ack;
        logic        cpu_clock_halt;
        logic        miss;
    } wcm_cpu_rsp_t;
    typedef struct packed {
        logic        req;
        logic [2:0]  adapter_op_code;
        logic [23:0] adapter_memory_address;
        logic [63:0] wdata;
    } wcm_adp_req_t;
    typedef struct packed {
        logic        ack;
        logic [63:0] rdata;
    } wcm_adp_rsp_t;
    typedef struct packed {
        logic        vld;
        wcm_mem_op_t op;
        wcm_size_t   sz;
        logic [23:0] addr;
        logic [63:0] wdata;
    } wcm_mem_cmd_t;
    typedef struct packed {
        logic        done;
        logic [63:0] cache_write_data_bus;
        logic [31:0] cpu_direct_read_word;
    } wcm_mem_rsp_t;
endpackage

// ==== design/wcm_top.sv ====
// The implementer's own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module wcm_top
    import wcm_pkg::*;
#(
    parameter int IDX_W   = IDX_W_D,
    parameter int REF_CNT = REF_CYC
) (
    // Clock and reset
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    // Central processor
    input  wire wcm_cpu_req_t cpu_req_in,
    output wcm_cpu_rsp_t      cpu_rsp_out,
    // Bus adapter
    input  wire wcm_adp_req_t adp_req_in,
    output wcm_adp_rsp_t      adp_rsp_out,
    // Main memory
    output wcm_mem_cmd_t      mem_cmd_out,
    input  wire wcm_mem_rsp_t mem_rsp_in,
    // Register bus
    input  wire logic [3:0]   avs_address_in,
    input  wire logic         avs_read_in,
    input  wire logic         avs_write_in,
    input  wire logic [31:0]  avs_writedata_in,
    input  wire logic [3:0]   avs_byteenable_in,
    output logic [31:0]       avs_readdata_out,
    output logic              avs_waitrequest_out
);
    localparam int DEPTH = 1 << IDX_W;

    typedef enum logic [2:0] {
        S_IDLE, S_REF, S_ADP_RD, S_ADP_WR, S_CPU_WR, S_FILL
    } wcm_fsm_t;

    typedef struct packed {
        wcm_fsm_t                   fsm;
        wcm_ent_t [1:0][DEPTH-1:0]  ent;
        wcm_mem_cmd_t               mem;
        wcm_cpu_rsp_t               cpu;
        wcm_adp_rsp_t               adp;
        logic [23:0]                fa;
        logic [RT_W-1:0]            rt;
        logic                       ref_due;
        logic [ROW_W-1:0]           row;
        logic                       dis;
        logic                       miss_seen;
        logic                       perr_seen;
        logic                       av_wait;
        logic [31:0]                av_rd;
    } wcm_st_t;

    wcm_st_t st;
    wcm_st_t nx;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [3:0] par4(input logic [31:0] w);
        logic [3:0] p;
        p = '0;
        for (int i = 0; i < 4; i++) begin
            p[i] = ^w[8*i +: 8];
        end
        return p;
    endfunction

    function automatic wcm_ent_t mk(input logic [31:0] d, input logic [TAG_W-1:0] t);
        wcm_ent_t e;
        e.data = d;
        e.dpar = par4(d);
        e.tag  = t;
        e.tpar = ^t;
        e.v    = 1'b1;
        return e;
    endfunction

    // ----------------------------------------
    // Processor lookup
    // ----------------------------------------
    logic [23:0]       ca;
    logic [IDX_W-1:0]  ci;
    logic              co;
    logic [TAG_W-1:0]  ct;
    wcm_ent_t          ce;
    logic              perr;
    logic              teq;
    logic              hit;
    logic [31:0]       cw;

    assign ca   = cpu_req_in.cpu_memory_address;
    assign ci   = ca[A_IDX_LO +: IDX_W];
    assign co   = ca[A_ODD];
    assign ct   = ca[A_TAG_HI:A_TAG_LO];
    assign ce   = st.ent[co][ci];
    assign teq  = ce.tag == ct;
    assign perr = ce.v && (par4(ce.data) != ce.dpar || ^ce.tag != ce.tpar);
    assign hit  = !st.dis && ce.v && teq && !perr;
    assign cw   = co ? cpu_req_in.wdata[31:0] : cpu_req_in.wdata[63:32];

    // ----------------------------------------
    // Adapter lookup
    // ----------------------------------------
    logic [23:0]       aa;
    logic [IDX_W-1:0]  ai;
    logic              ao;
    logic [TAG_W-1:0]  at;
    logic [2:0]        aop;

    assign aa  = adp_req_in.adapter_memory_address;
    assign ai  = aa[A_IDX_LO +: IDX_W];
    assign ao  = aa[A_ODD];
    assign at  = aa[A_TAG_HI:A_TAG_LO];
    assign aop = adp_req_in.adapter_op_code;

    // ----------------------------------------
    // Request qualification
    // ----------------------------------------
    // A request is masked in the cycle its ack is shown, since the
    // requester only drops it at that edge.
    logic adp;
    logic cpu_rd;
    logic cpu_wr;
    logic cpu_hw;
    logic free;
    logic rd_go;
    logic [IDX_W-1:0] fi;

    assign adp    = adp_req_in.req && !st.adp.ack;
    assign cpu_rd = cpu_req_in.op == CPU_READ && cpu_req_in.cache_read_request_bit
                    && !st.cpu.ack;
    assign cpu_wr = (cpu_req_in.op == CPU_WR_BYTE || cpu_req_in.op == CPU_WR_WORD
                    || cpu_req_in.op == CPU_WR_DWORD) && !st.cpu.ack;
    assign cpu_hw = cpu_req_in.op == CPU_WR_HALF && !st.cpu.ack;
    assign free   = st.fsm == S_IDLE && !st.ref_due;
    assign rd_go  = free && !adp && !cpu_wr && !cpu_hw && cpu_rd;
    assign fi     = st.fa[A_IDX_LO +: IDX_W];

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic [31:0] w;
        w          = ce.data;
        nx         = st;
        nx.cpu.ack  = 1'b0;
        nx.cpu.load = 1'b0;
        nx.cpu.miss = 1'b0;
        nx.adp.ack  = 1'b0;

        // Refresh interval keeps running through every other operation
        if (st.rt == RT_W'(REF_CNT - 1)) begin
            nx.rt      = '0;
            nx.ref_due = 1'b1;
        end else begin
            nx.rt = st.rt + 1'b1;
        end

        // Register bus: answer one cycle after the request, commit on
        // the edge where waitrequest is seen low
        if (!st.av_wait) begin
            nx.av_wait = 1'b1;
            if (avs_write_in && avs_byteenable_in[0]) begin
                if (avs_address_in == REG_CTRL) begin
                    nx.dis = avs_writedata_in[CTRL_DIS];
                end else if (avs_address_in == REG_STAT) begin
                    if (avs_writedata_in[STAT_MISS]) begin
                        nx.miss_seen = 1'b0;
                    end
                    if (avs_writedata_in[STAT_PERR]) begin
                        nx.perr_seen = 1'b0;
                    end
                end
            end
        end else if (avs_read_in || avs_write_in) begin
            nx.av_wait = 1'b0;
            nx.av_rd   = '0;
            if (avs_address_in == REG_CTRL) begin
                nx.av_rd[CTRL_DIS] = st.dis;
            end else if (avs_address_in == REG_STAT) begin
                nx.av_rd[STAT_MISS] = st.miss_seen;
                nx.av_rd[STAT_PERR] = st.perr_seen;
                nx.av_rd[STAT_BUSY] = st.fsm != S_IDLE;
                nx.av_rd[STAT_ROW +: ROW_W] = st.row;
            end
        end

        case (st.fsm)
            S_IDLE: begin
                if (st.ref_due) begin
                    nx.mem.vld  = 1'b1;
                    nx.mem.op   = MEM_REFRESH;
                    nx.mem.addr = '0;
                    nx.mem.addr[A_ROW_LO +: ROW_W] = st.row;
                    nx.fsm      = S_REF;
                end else if (adp) begin
                    nx.mem.addr  = aa;
                    nx.mem.wdata = adp_req_in.wdata;
                    case (aop)
                        ADP_RD_DW: begin
                            nx.mem.vld = 1'b1;
                            nx.mem.op  = MEM_READ;
                            nx.fsm     = S_ADP_RD;
                        end
                        ADP_WR_B, ADP_WR_HW, ADP_WR_W, ADP_WR_DW: begin
                            nx.mem.vld = 1'b1;
                            nx.mem.op  = MEM_WRITE;
                            nx.mem.sz  = aop == ADP_WR_B  ? SZ_BYTE :
                                         aop == ADP_WR_HW ? SZ_HALF :
                                         aop == ADP_WR_W  ? SZ_WORD : SZ_DWORD;
                            nx.fsm     = S_ADP_WR;
                            // Invalidate only; never allocate
                            for (int s = 0; s < 2; s++) begin
                                if ((aop == ADP_WR_DW || ao == s[0])
                                    && st.ent[s][ai].tag == at) begin
                                    nx.ent[s][ai].v = 1'b0;
                                end
                            end
                        end
                        ADP_IPC: begin
                            nx.cpu.memory_data_register   = adp_req_in.wdata[31:0];
                            nx.cpu.drive = 1'b0;
                            nx.cpu.load  = 1'b1;
                            nx.adp.ack   = 1'b1;
                        end
                        default: begin
                            nx.adp.ack = 1'b1;
                        end
                    endcase
                end else if (cpu_wr) begin
                    nx.mem.vld   = 1'b1;
                    nx.mem.op    = MEM_WRITE;
                    nx.mem.addr  = ca;
                    nx.mem.wdata = cpu_req_in.wdata;
                    nx.cpu.ack   = 1'b1;
                    nx.fsm       = S_CPU_WR;
                    case (cpu_req_in.op)
                        CPU_WR_BYTE: begin
                            nx.mem.sz = SZ_BYTE;
                            if (ce.v && teq) begin
                                w[8*(3-ca[1:0]) +: 8] = cw[8*(3-ca[1:0]) +: 8];
                                nx.ent[co][ci] = mk(w, ct);
                            end
                        end
                        CPU_WR_WORD: begin
                            nx.mem.sz = SZ_WORD;
                            if (teq) begin
                                nx.ent[co][ci] = mk(cw, ct);
                            end
                        end
                        default: begin
                            nx.mem.sz = SZ_DWORD;
                            if (st.ent[0][ci].tag == ct) begin
                                nx.ent[0][ci] = mk(cpu_req_in.wdata[63:32], ct);
                            end
                            if (st.ent[1][ci].tag == ct) begin
                                nx.ent[1][ci] = mk(cpu_req_in.wdata[31:0], ct);
                            end
                        end
                    endcase
                end else if (cpu_hw) begin
                    nx.cpu.ack = 1'b1;
                end else if (cpu_rd) begin
                    if (hit) begin
                        nx.cpu.memory_data_register   = ce.data;
                        nx.cpu.drive = 1'b1;
                        nx.cpu.load  = 1'b1;
                        nx.cpu.ack   = 1'b1;
                    end else begin
                        nx.cpu.miss  = 1'b1;
                        nx.miss_seen = 1'b1;
                        if (perr) begin
                            nx.perr_seen = 1'b1;
                        end
                        nx.mem.vld  = 1'b1;
                        nx.mem.op   = MEM_READ;
                        nx.mem.sz   = SZ_DWORD;
                        nx.mem.addr = ca;
                        nx.fa       = ca;
                        nx.fsm      = S_FILL;
                    end
                end
            end
            S_REF: begin
                if (mem_rsp_in.done) begin
                    nx.mem.vld = 1'b0;
                    nx.ref_due = st.rt == RT_W'(REF_CNT - 1);          // Set wins
                    nx.row     = st.row + 1'b1;
                    nx.fsm     = S_IDLE;
                end
            end
            S_ADP_RD: begin
                if (mem_rsp_in.done) begin
                    nx.mem.vld   = 1'b0;
                    nx.adp.rdata = mem_rsp_in.cache_write_data_bus;
                    nx.adp.ack   = 1'b1;
                    nx.fsm       = S_IDLE;
                end
            end
            S_ADP_WR, S_CPU_WR: begin
                if (mem_rsp_in.done) begin
                    nx.mem.vld = 1'b0;
                    nx.adp.ack = st.fsm == S_ADP_WR;
                    nx.fsm     = S_IDLE;
                end
            end
            S_FILL: begin
                if (mem_rsp_in.done) begin
                    // Even and odd word of the refill written in the same cycle
                    nx.ent[0][fi] = mk(mem_rsp_in.cache_write_data_bus[63:32],
                                       st.fa[A_TAG_HI:A_TAG_LO]);
                    nx.ent[1][fi] = mk(mem_rsp_in.cache_write_data_bus[31:0],
                                       st.fa[A_TAG_HI:A_TAG_LO]);
                    nx.cpu.memory_data_register    = mem_rsp_in.cpu_direct_read_word;
                    nx.cpu.drive  = 1'b0;
                    nx.cpu.load   = 1'b1;
                    nx.cpu.ack    = 1'b1;
                    nx.mem.vld    = 1'b0;
                    nx.fsm        = S_IDLE;
                end
            end
            default: begin
                nx.fsm = S_IDLE;
            end
        endcase

        // Stale contents after re-enable are dropped wholesale
        if (st.dis && !nx.dis) begin
            for (int i = 0; i < DEPTH; i++) begin
                nx.ent[0][i].v = 1'b0;
                nx.ent[1][i].v = 1'b0;
            end
        end

        // Halt any processor request that is not completed this cycle
        nx.cpu.cpu_clock_halt = (cpu_rd || cpu_wr || cpu_hw) && !nx.cpu.ack;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st         <= '0;
            st.av_wait <= 1'b1;
        end else begin
            st <= nx;
        end
    end

    assign cpu_rsp_out         = st.cpu;
    assign adp_rsp_out         = st.adp;
    assign mem_cmd_out         = st.mem;
    assign avs_readdata_out    = st.av_rd;
    assign avs_waitrequest_out = st.av_wait;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence s_miss;
        rd_go && !hit;
    endsequence
    sequence s_fill_done;
        st.fsm == S_FILL && mem_rsp_in.done;
    endsequence

    chk_hit_drive: assert property (rd_go && hit |=>
        cpu_rsp_out.drive && cpu_rsp_out.load && cpu_rsp_out.memory_data_register == $past(ce.data))
        else $error("hit did not drive cache word");
    chk_miss_halt: assert property (s_miss |=>
        cpu_rsp_out.miss && cpu_rsp_out.cpu_clock_halt && st.fsm == S_FILL)
        else $error("miss did not halt and start refill");
    chk_miss_log: assert property (s_miss |=> st.miss_seen)
        else $error("miss not recorded");
    chk_fill_valid: assert property (s_fill_done |=>
        st.ent[0][$past(fi)].v && st.ent[1][$past(fi)].v)
        else $error("refill left word invalid");
    chk_fill_direct: assert property (s_fill_done |=> cpu_rsp_out.load
        && !cpu_rsp_out.drive && !cpu_rsp_out.cpu_clock_halt)
        else $error("refill word not forwarded");
    chk_perr_miss: assert property (rd_go && perr |=> ##0 st.perr_seen
        && st.fsm == S_FILL)
        else $error("parity error did not force miss");
    chk_dis_read: assert property (rd_go && st.dis |=> st.mem.op == MEM_READ)
        else $error("disabled cache served a read");
    chk_row_step: assert property (st.fsm == S_REF && mem_rsp_in.done |=>
        st.row == $past(st.row) + 8'h01)
        else $error("refresh row did not step");
    chk_ref_first: assert property (st.fsm == S_IDLE && st.ref_due |=>
        st.fsm == S_REF && mem_cmd_out.op == MEM_REFRESH)
        else $error("refresh lost priority");
    chk_adp_addr: assert property (free && adp && aop != ADP_IPC
        && aop <= ADP_WR_B |=> mem_cmd_out.addr == $past(aa))
        else $error("adapter address not routed");
    chk_adp_read: assert property (st.fsm == S_ADP_RD && mem_rsp_in.done
        |=> adp_rsp_out.ack && $stable(st.ent) && !cpu_rsp_out.load)
        else $error("adapter read touched cache");
    chk_reen_clear: assert property (st.dis && !nx.dis |=>
        !st.ent[0][0].v && !st.ent[1][0].v)
        else $error("re-enable left entries valid");
endmodule

// ==== verif/wcm_mem_model.sv ====
`timescale 1ns/100ps
module wcm_mem_model
    import wcm_pkg::*;
(
    // Clock
    input  wire logic         clk_in,
    // Controller side
    input  wire wcm_mem_cmd_t mem_cmd_in,
    output wcm_mem_rsp_t      mem_rsp_out
);
    logic [2:0]  wait_cnt = 3'h0;
    logic        served   = 1'b0;
    logic [31:0] ev;
    assign ev = {8'h00, mem_cmd_in.addr[23:3], 3'h0};
    initial mem_rsp_out = '0;
    // Data lines carry noise outside done so a stale word never passes
    always @(posedge clk_in) begin
        mem_rsp_out.done <= 1'b0;
        mem_rsp_out.cache_write_data_bus <= {$urandom, $urandom};
        mem_rsp_out.cpu_direct_read_word <= $urandom;
        if (mem_cmd_in.vld !== 1'b1) begin
            served <= 1'b0;
            wait_cnt <= 3'($urandom_range(4, 0));
        end else if (!served) begin
            if (wait_cnt == 3'h0) begin
                mem_rsp_out.done <= 1'b1;
                mem_rsp_out.cache_write_data_bus <= {ev, ~ev};
                mem_rsp_out.cpu_direct_read_word <= mem_cmd_in.addr[2] ? ~ev : ev;
                served <= 1'b1;
            end else begin
                wait_cnt <= wait_cnt - 3'h1;
            end
        end
    end
endmodule

// ==== verif/write_through_cache_memctl_tb.sv ====
`timescale 1ns/100ps
module write_through_cache_memctl_tb;
    import wcm_pkg::*;
    logic         clk_in = 1'b0;
    logic         rst_in = 1'b1;
    wcm_cpu_req_t cpu_req_in = '0;
    wcm_cpu_rsp_t cpu_rsp_out;
    wcm_adp_req_t adp_req_in = '0;
    wcm_adp_rsp_t adp_rsp_out;
    wcm_mem_cmd_t mem_cmd_out;
    wcm_mem_rsp_t mem_rsp_in;
    logic [3:0]   avs_address_in = 4'h0;
    logic         avs_read_in = 1'b0;
    logic         avs_write_in = 1'b0;
    logic [31:0]  avs_writedata_in = 32'h0000_0000;
    logic [31:0]  avs_readdata_out;
    logic         avs_waitrequest_out;
    logic [32:0]  exp_q[$];
    logic [32:0]  e;
    logic [31:0]  rd;
    logic [23:0]  a;
    logic [23:0]  b;
    logic [23:0]  c;
    logic [7:0]   last_row;
    bit           row_seen = 0;
    int           fail_count = 0;
    int           check_count = 0;
    int           cyc = 0;
    wcm_top #(.REF_CNT(40)) u_dut (.clk_in(clk_in), .rst_in(rst_in), .cpu_req_in(cpu_req_in),
        .cpu_rsp_out(cpu_rsp_out), .adp_req_in(adp_req_in), .adp_rsp_out(adp_rsp_out),
        .mem_cmd_out(mem_cmd_out), .mem_rsp_in(mem_rsp_in), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(4'hf),
        .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out));
    wcm_mem_model u_mem (.clk_in(clk_in), .mem_cmd_in(mem_cmd_out), .mem_rsp_out(mem_rsp_in));
    initial forever #20 clk_in = ~clk_in;
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    function automatic logic [31:0] word(input logic [23:0] ad);
        return ad[2] ? ~{8'h00, ad[23:3], 3'h0} : {8'h00, ad[23:3], 3'h0};
    endfunction
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cpu(input wcm_cpu_op_t op, input logic [23:0] ad, input logic [63:0] d);
        @(posedge clk_in);
        cpu_req_in <= '{op, 1'b1, ad, d};
        do @(posedge clk_in); while (cpu_rsp_out.ack !== 1'b1);
        cpu_req_in.op <= CPU_NONE;
    endtask
    task automatic rd_exp(input logic [23:0] ad, input logic hit);
        exp_q.push_back({hit, word(ad)});
        cpu(CPU_READ, ad, 64'h0);
    endtask
    task automatic adp(input logic [2:0] op, input logic [23:0] ad, input logic [63:0] d);
        @(posedge clk_in);
        adp_req_in <= '{1'b1, op, ad, d};
        do @(posedge clk_in); while (adp_rsp_out.ack !== 1'b1);
        adp_req_in.req <= 1'b0;
    endtask
    task automatic avs(input logic w, input logic [3:0] ad, input logic [31:0] d);
        @(posedge clk_in);
        {avs_read_in, avs_write_in, avs_address_in, avs_writedata_in} <= {!w, w, ad, d};
        do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
        rd = avs_readdata_out;
        {avs_read_in, avs_write_in} <= 2'b00;
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // Result watcher
    // ----------------------------------------
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cpu_rsp_out.load === 1'b1) begin
            e = exp_q.size() ? exp_q.pop_front() : 33'h0;
            chk("cpu word", e, {cpu_rsp_out.drive, cpu_rsp_out.memory_data_register});
        end
        if (cpu_rsp_out.miss === 1'b1) chk("halt", 1, cpu_rsp_out.cpu_clock_halt);
        if (mem_cmd_out.vld === 1'b1 && mem_cmd_out.op === MEM_REFRESH && mem_rsp_in.done) begin
            if (row_seen) chk("row", last_row + 8'h1, mem_cmd_out.addr[17:10]);
            row_seen = 1;
            last_row = mem_cmd_out.addr[17:10];
        end
        if (cyc > 20000) begin
            fail_count++;
            wrap_up();
        end
    end
    initial begin
        void'($urandom(32'hb905da73));
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        a = 24'($urandom) & 24'hff_fffb;
        b = a ^ 24'h00_8000;
        rd_exp(a, 0);
        rd_exp(a, 1);
        rd_exp(a | 24'h4, 1);
        exp_q.push_back({1'b1, 32'h1234_5678});
        cpu(CPU_WR_WORD, a, {32'h1234_5678, 32'h0000_0000});
        cpu(CPU_READ, a, 64'h0);
        $display("cpu read and write test done");
        adp(ADP_WR_DW, a, {$urandom, $urandom});
        rd_exp(a, 0);
        adp(ADP_RD_DW, b, 64'h0);
        chk("adapter data", {word(b & 24'hff_fffb), word(b | 24'h4)}, adp_rsp_out.rdata);
        rd_exp(b, 0);
        $display("adapter test done");
        avs(0, 4'h4, 0);
        chk("miss seen", 1, rd[0]);
        avs(1, 4'h0, 1);
        rd_exp(b, 0);
        avs(1, 4'h0, 0);
        rd_exp(b, 0);
        avs(0, 4'h8, 0);
        chk("unmapped", 0, rd);
        $display("register test done");
        c = b & 24'hff_fff8;
        exp_q.push_back({1'b1, word(c) | 32'hab00_0000});
        cpu(CPU_WR_BYTE, c, {32'hab00_0000, 32'h0000_0000});
        cpu(CPU_WR_HALF, c, {64{1'b1}});
        cpu(CPU_READ, c, 64'h0);
        exp_q.push_back({1'b1, 32'h1111_2222});
        exp_q.push_back({1'b1, 32'h3333_4444});
        cpu(CPU_WR_DWORD, c, 64'h1111_2222_3333_4444);
        cpu(CPU_READ, c, 64'h0);
        cpu(CPU_READ, c | 24'h4, 64'h0);
        adp(ADP_WR_B, c | 24'h4, 64'h0);
        adp(3'h6, c, 64'h0);
        exp_q.push_back({1'b1, 32'h1111_2222});
        cpu(CPU_READ, c, 64'h0);
        rd_exp(c | 24'h4, 0);
        exp_q.push_back({1'b0, 32'h5a5a_0001});
        adp(ADP_IPC, c, 64'h5a5a_0001);
        $display("cache write test done");
        repeat (150) @(posedge clk_in);
        chk("refresh seen", 1, row_seen);
        $display("refresh test done");
        wrap_up();
    end
endmodule
